// ---- design/iag_pkg.sv ----
// Constants and types shared by the indirect address generator
package iag_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int BANK_W = 4;
    localparam int HIGH_W = ADDR_W - DATA_W;
    localparam int NUM_PTR = 3;
    localparam int SEL_W = 2;
    localparam int LIT_W = 6;
    localparam int OFS_W = 3;
    localparam int BLK_W = ADDR_W - OFS_W;

    // ------------------------------------------------------------
    // Access map
    // ------------------------------------------------------------
    // Last access-bank offset that maps to the low bank or the window
    localparam logic [DATA_W-1:0] ACCESS_LIMIT = 8'h5F;
    localparam logic [BANK_W-1:0] LOW_BANK = 4'h0;
    localparam logic [BANK_W-1:0] SFR_BANK = 4'hF;
    // Eight-byte block of the first pointer; later pointers sit lower
    localparam logic [BLK_W-1:0] PTR_BLK_TOP = 9'h1FD;
    localparam logic [SEL_W-1:0] WINDOW_PTR = 2'h2;

    // ------------------------------------------------------------
    // Reset and step values
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] PTR_RST = 12'h000;
    localparam logic [ADDR_W-1:0] PTR_STEP = 12'h001;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [HIGH_W-1:0] HIGH_PAD = 4'h0;

    // ------------------------------------------------------------
    // Register kind inside a pointer block; value is the low offset
    // ------------------------------------------------------------
    typedef enum logic [OFS_W-1:0] {
        K_NONE    = 3'h0,
        K_LOW     = 3'h1,
        K_HIGH    = 3'h2,
        K_ACCOFS  = 3'h3,
        K_PRE_INCREMENT_OPERAND  = 3'h4,
        K_POST_DECREMENT_OPERAND = 3'h5,
        K_POST_INCREMENT_OPERAND = 3'h6,
        K_PLAIN   = 3'h7
    } iag_kind_t;

    // Where a read answer comes from
    typedef enum logic [1:0] {
        SRC_MEM  = 2'h0,
        SRC_PTR  = 2'h1,
        SRC_ZERO = 2'h3
    } iag_src_t;

endpackage : iag_pkg

// ---- design/iag_addr_decode.sv ----
// Decoder that finds pointer bytes and virtual operands in an address
`timescale 1ns/1ps
`default_nettype none

module iag_addr_decode (
    // Address under test
    input wire logic [iag_pkg::ADDR_W-1:0] i_addr,
    // Decode result
    output logic o_hit,
    output logic [iag_pkg::SEL_W-1:0] o_sel,
    output iag_pkg::iag_kind_t o_kind
);
    import iag_pkg::*;

    logic [NUM_PTR-1:0] blk_hit;

    // ------------------------------------------------------------
    // One block compare per pointer
    // ------------------------------------------------------------
    for (genvar n = 0; n < NUM_PTR; n++) begin : gen_blk
        localparam logic [BLK_W-1:0] BLK = PTR_BLK_TOP - BLK_W'(n);
        assign blk_hit[n] = (i_addr[ADDR_W-1:OFS_W] == BLK) &&
                            (i_addr[OFS_W-1:0] != K_NONE);
    end

    always_comb begin
        o_hit = 1'b0;
        o_sel = '0;
        o_kind = K_NONE;
        for (int n = 0; n < NUM_PTR; n++) begin
            if (blk_hit[n]) begin
                o_hit = 1'b1;
                o_sel = SEL_W'(n);
                o_kind = iag_kind_t'(i_addr[OFS_W-1:0]);
            end
        end
    end

endmodule : iag_addr_decode
`default_nettype wire

// ---- design/iag_indirect_addr.sv ----
// Data-memory address generator with pointer pairs and virtual operands
//
// Behaviour
// RULE_01: Each pointer pair has three stepping virtual operands, one accumulator offset operand, plus the plain one.
// RULE_02: Post-decrement addresses the pointer, then lowers the pair by one.
// RULE_03: Post-increment addresses the pointer, then raises the pair by one.
// RULE_04: Pre-increment raises the pair by one and addresses the new value.
// RULE_05: Accumulator offset addresses pointer plus signed accumulator; nothing changes.
// RULE_06: Plain indirect operand addresses the pointer and leaves it alone.
// RULE_07: Steps act on the whole 12-bit pair with carry and borrow.
// RULE_08: Pointer steps never touch arithmetic status flags.
// RULE_09: Indirect read aimed at another virtual operand returns zero.
// RULE_10: Indirect write aimed at another virtual operand does nothing.
// RULE_11: Virtual operand write onto a pointer pair stores it without stepping.
// RULE_12: Pointer bytes are registers reachable by direct addressing.
// RULE_13: Indirect access reaches all other special registers.
// RULE_14: Extended set adds pointer literal add and subtract; memory unchanged.
// RULE_15: Indexed mode maps access offsets 00h-5Fh to third pointer plus offset.
// RULE_16: Access offsets above 05Fh keep the normal access bank map.
// RULE_17: Banked instructions use bank select register direct addressing.
// RULE_18: Named indirect operands keep standard indirect behaviour in indexed mode.
// RULE_19: Bank selection works the same with the extended set enabled.
// RULE_20: Pointer address is high nibble over low byte, twelve bits.
`timescale 1ns/1ps
`default_nettype none

module iag_indirect_addr (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rstn,
    // Data access request from the execution unit
    input wire logic i_acc_valid,
    input wire logic i_acc_write,
    input wire logic i_acc_banked,
    input wire logic [iag_pkg::DATA_W-1:0] i_acc_file,
    input wire logic [iag_pkg::DATA_W-1:0] i_acc_wdata,
    input wire logic [iag_pkg::BANK_W-1:0] i_bank_select,
    input wire logic [iag_pkg::DATA_W-1:0] i_accum,
    input wire logic i_ext_enable,
    // Pointer literal arithmetic
    input wire logic i_arith_valid,
    input wire logic i_arith_sub,
    input wire logic [iag_pkg::SEL_W-1:0] i_arith_sel,
    input wire logic [iag_pkg::LIT_W-1:0] i_arith_lit,
    // Data memory
    output logic [iag_pkg::ADDR_W-1:0] o_mem_addr,
    output logic o_mem_rd,
    output logic o_mem_wr,
    output logic [iag_pkg::DATA_W-1:0] o_mem_wdata,
    input wire logic [iag_pkg::DATA_W-1:0] i_mem_rdata,
    // Read answer to the execution unit
    output logic [iag_pkg::DATA_W-1:0] o_rdata,
    output logic o_rdata_valid
);
    import iag_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    wire [NUM_PTR-1:0][ADDR_W-1:0] ptr_all;
    logic arith_take;
    logic acc_take;
    logic [ADDR_W-1:0] eff_addr;
    logic eff_hit;
    logic [SEL_W-1:0] eff_sel;
    iag_kind_t eff_kind;
    logic is_ind;
    logic [ADDR_W-1:0] sel_ptr;
    logic [ADDR_W-1:0] ind_addr;
    logic [ADDR_W-1:0] tgt_addr;
    logic tgt_hit;
    logic [SEL_W-1:0] tgt_sel;
    iag_kind_t tgt_kind;
    logic tgt_virtual;
    logic tgt_ptr;
    logic tgt_mem;
    logic ptr_wr;
    logic mod_block;
    logic [ADDR_W-1:0] tgt_ptr_val;
    logic [DATA_W-1:0] ptr_rd_byte;
    logic [ADDR_W-1:0] mem_addr_q;
    logic mem_rd_q;
    logic mem_wr_q;
    logic [DATA_W-1:0] mem_wdata_q;
    logic rd_pend_q;
    iag_src_t rd_src_q;
    logic [DATA_W-1:0] rd_byte_q;
    logic [DATA_W-1:0] rdata_q;
    logic rdata_valid_q;
    logic [SEL_W-1:0] chk_sel_q;
    logic [ADDR_W-1:0] chk_ptr;

    // ------------------------------------------------------------
    // Request arbitration
    // ------------------------------------------------------------
    // Literal arithmetic exists only with the extended set
    assign arith_take = i_arith_valid && i_ext_enable; // RULE_14
    assign acc_take = i_acc_valid && !arith_take;

    // ------------------------------------------------------------
    // Effective address of the instruction operand
    // ------------------------------------------------------------
    always_comb begin
        if (i_acc_banked) begin
            eff_addr = {i_bank_select, i_acc_file}; // RULE_17 RULE_19
        end else if (i_ext_enable && (i_acc_file <= ACCESS_LIMIT)) begin
            eff_addr = ptr_all[WINDOW_PTR] + {HIGH_PAD, i_acc_file}; // RULE_15
        end else if (i_acc_file <= ACCESS_LIMIT) begin
            eff_addr = {LOW_BANK, i_acc_file};
        end else begin
            eff_addr = {SFR_BANK, i_acc_file}; // RULE_16
        end
    end

    iag_addr_decode u_eff_decode (
        .i_addr (eff_addr),
        .o_hit  (eff_hit),
        .o_sel  (eff_sel),
        .o_kind (eff_kind)
    );

    // Virtual operands sit in the upper access map, so the window never hides them
    assign is_ind = eff_hit && (eff_kind != K_LOW) && (eff_kind != K_HIGH); // RULE_18
    assign sel_ptr = ptr_all[eff_sel];

    // ------------------------------------------------------------
    // Indirect target address
    // ------------------------------------------------------------
    always_comb begin
        case (eff_kind) // RULE_01
            K_PRE_INCREMENT_OPERAND: ind_addr = sel_ptr + PTR_STEP; // RULE_04
            K_ACCOFS: ind_addr = sel_ptr +
                {{(ADDR_W-DATA_W){i_accum[DATA_W-1]}}, i_accum}; // RULE_05
            K_POST_DECREMENT_OPERAND: ind_addr = sel_ptr; // RULE_02
            K_POST_INCREMENT_OPERAND: ind_addr = sel_ptr; // RULE_03
            default: ind_addr = sel_ptr; // RULE_06
        endcase
    end

    assign tgt_addr = is_ind ? ind_addr : eff_addr;

    iag_addr_decode u_tgt_decode (
        .i_addr (tgt_addr),
        .o_hit  (tgt_hit),
        .o_sel  (tgt_sel),
        .o_kind (tgt_kind)
    );

    // Pointer aimed at a virtual operand reaches nothing
    assign tgt_virtual = is_ind && tgt_hit &&
                         (tgt_kind != K_LOW) && (tgt_kind != K_HIGH); // RULE_09 RULE_10
    assign tgt_ptr = tgt_hit && ((tgt_kind == K_LOW) || (tgt_kind == K_HIGH)); // RULE_12
    // Any other special register passes to memory as usual
    assign tgt_mem = !tgt_virtual && !tgt_ptr; // RULE_13

    assign ptr_wr = acc_take && i_acc_write && tgt_ptr;
    // Writing a pair through its own operand stores the value unstepped
    assign mod_block = ptr_wr && is_ind && (tgt_sel == eff_sel); // RULE_11

    assign tgt_ptr_val = ptr_all[tgt_sel];
    assign ptr_rd_byte = (tgt_kind == K_HIGH) ?
                         {HIGH_PAD, tgt_ptr_val[ADDR_W-1:DATA_W]} :
                         tgt_ptr_val[DATA_W-1:0]; // RULE_20

    // ------------------------------------------------------------
    // Pointer pairs
    // ------------------------------------------------------------
    for (genvar n = 0; n < NUM_PTR; n++) begin : gen_ptr
        logic [ADDR_W-1:0] ptr_q;
        logic [ADDR_W-1:0] ptr_d;

        assign ptr_all[n] = ptr_q;

        // Full-width steps carry between the bytes; no flag is produced
        always_comb begin
            ptr_d = ptr_q;
            if (arith_take && (i_arith_sel == SEL_W'(n))) begin
                if (i_arith_sub) begin
                    ptr_d = ptr_q - {{(ADDR_W-LIT_W){1'b0}}, i_arith_lit}; // RULE_14
                end else begin
                    ptr_d = ptr_q + {{(ADDR_W-LIT_W){1'b0}}, i_arith_lit}; // RULE_14
                end
            end else if (acc_take) begin
                if (is_ind && (eff_sel == SEL_W'(n)) && !mod_block) begin
                    case (eff_kind)
                        K_POST_DECREMENT_OPERAND: ptr_d = ptr_q - PTR_STEP; // RULE_02 RULE_07 RULE_08
                        K_POST_INCREMENT_OPERAND: ptr_d = ptr_q + PTR_STEP; // RULE_03 RULE_07 RULE_08
                        K_PRE_INCREMENT_OPERAND: ptr_d = ptr_q + PTR_STEP; // RULE_04 RULE_07 RULE_08
                        default: ptr_d = ptr_q; // RULE_05 RULE_06
                    endcase
                end
                if (ptr_wr && (tgt_sel == SEL_W'(n))) begin
                    if (tgt_kind == K_HIGH) begin
                        ptr_d[ADDR_W-1:DATA_W] = i_acc_wdata[HIGH_W-1:0]; // RULE_12
                    end else begin
                        ptr_d[DATA_W-1:0] = i_acc_wdata; // RULE_12
                    end
                end
            end
        end

        always_ff @(posedge i_clock) begin
            if (!i_rstn) begin
                ptr_q <= PTR_RST;
            end else begin
                ptr_q <= ptr_d;
            end
        end
    end

    // ------------------------------------------------------------
    // Memory request stage
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            mem_addr_q <= PTR_RST;
            mem_rd_q <= 1'b0;
            mem_wr_q <= 1'b0;
            mem_wdata_q <= ZERO_BYTE;
        end else begin
            mem_addr_q <= tgt_addr;
            mem_rd_q <= acc_take && !i_acc_write && tgt_mem;
            mem_wr_q <= acc_take && i_acc_write && tgt_mem; // RULE_10
            mem_wdata_q <= i_acc_wdata;
        end
    end

    assign o_mem_addr = mem_addr_q;
    assign o_mem_rd = mem_rd_q;
    assign o_mem_wr = mem_wr_q;
    assign o_mem_wdata = mem_wdata_q;

    // ------------------------------------------------------------
    // Read answer source
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            rd_pend_q <= 1'b0;
            rd_src_q <= SRC_MEM;
            rd_byte_q <= ZERO_BYTE;
        end else begin
            rd_pend_q <= acc_take && !i_acc_write;
            if (tgt_virtual) begin
                rd_src_q <= SRC_ZERO; // RULE_09
            end else if (tgt_ptr) begin
                rd_src_q <= SRC_PTR; // RULE_12
            end else begin
                rd_src_q <= SRC_MEM;
            end
            rd_byte_q <= ptr_rd_byte;
        end
    end

    // ------------------------------------------------------------
    // Read answer
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            rdata_q <= ZERO_BYTE;
            rdata_valid_q <= 1'b0;
        end else begin
            rdata_valid_q <= rd_pend_q;
            if (rd_pend_q) begin
                case (rd_src_q)
                    SRC_MEM: rdata_q <= i_mem_rdata;
                    SRC_PTR: rdata_q <= rd_byte_q;
                    SRC_ZERO: rdata_q <= ZERO_BYTE; // RULE_09
                    default: rdata_q <= ZERO_BYTE;
                endcase
            end
        end
    end

    assign o_rdata = rdata_q;
    assign o_rdata_valid = rdata_valid_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            chk_sel_q <= '0;
        end else begin
            chk_sel_q <= eff_sel;
        end
    end

    assign chk_ptr = ptr_all[chk_sel_q];

    a_post_decrement_operand_step: assert property ( // RULE_02
        @(posedge i_clock) disable iff (!i_rstn)
        (acc_take && is_ind && (eff_kind == K_POST_DECREMENT_OPERAND) && !mod_block)
        |=> (chk_ptr == $past(sel_ptr) - PTR_STEP))
        else $error("post-decrement did not lower the pointer by one");

    a_post_increment_operand_step: assert property ( // RULE_03
        @(posedge i_clock) disable iff (!i_rstn)
        (acc_take && is_ind && (eff_kind == K_POST_INCREMENT_OPERAND) && !mod_block && tgt_mem)
        |=> (chk_ptr == $past(sel_ptr) + PTR_STEP) && (o_mem_addr == $past(sel_ptr)))
        else $error("post-increment address or step wrong");

    a_pre_increment_operand_addr: assert property ( // RULE_04
        @(posedge i_clock) disable iff (!i_rstn)
        (acc_take && is_ind && (eff_kind == K_PRE_INCREMENT_OPERAND) && !mod_block && tgt_mem)
        |=> (o_mem_addr == $past(sel_ptr) + PTR_STEP) && (chk_ptr == o_mem_addr))
        else $error("pre-increment did not address the raised pointer");

    a_accofs_keep: assert property ( // RULE_05
        @(posedge i_clock) disable iff (!i_rstn)
        (acc_take && is_ind && (eff_kind == K_ACCOFS) && !ptr_wr)
        |=> (chk_ptr == $past(sel_ptr)))
        else $error("accumulator offset access changed the pointer");

    a_plain_addr: assert property ( // RULE_06
        @(posedge i_clock) disable iff (!i_rstn)
        (acc_take && is_ind && (eff_kind == K_PLAIN) && tgt_mem)
        |=> (o_mem_addr == $past(sel_ptr)) && (o_mem_rd || o_mem_wr)
            && (chk_ptr == $past(sel_ptr)))
        else $error("plain indirect access wrong address or moved pointer");

    a_virt_read_zero: assert property ( // RULE_09
        @(posedge i_clock) disable iff (!i_rstn)
        (acc_take && !i_acc_write && tgt_virtual)
        |=> !o_mem_rd ##1 (o_rdata_valid && (o_rdata == ZERO_BYTE)))
        else $error("read of a virtual operand through a pointer not zero");

    a_virt_write_nop: assert property ( // RULE_10
        @(posedge i_clock) disable iff (!i_rstn)
        (acc_take && i_acc_write && tgt_virtual)
        |=> !o_mem_wr)
        else $error("write to a virtual operand through a pointer reached memory");

    a_self_write_keep: assert property ( // RULE_11
        @(posedge i_clock) disable iff (!i_rstn)
        mod_block
        |=> (chk_ptr == (($past(tgt_kind) == K_HIGH) ?
            {$past(i_acc_wdata[HIGH_W-1:0]), $past(sel_ptr[DATA_W-1:0])} :
            {$past(sel_ptr[ADDR_W-1:DATA_W]), $past(i_acc_wdata)})))
        else $error("pointer written through own operand was stepped");

    a_window_map: assert property ( // RULE_15
        @(posedge i_clock) disable iff (!i_rstn)
        (acc_take && i_ext_enable && !i_acc_banked && (i_acc_file <= ACCESS_LIMIT)
         && !is_ind && tgt_mem)
        |=> (o_mem_addr == $past(ptr_all[WINDOW_PTR]) + {HIGH_PAD, $past(i_acc_file)}))
        else $error("indexed access not mapped into the pointer window");

    a_banked_direct: assert property ( // RULE_17
        @(posedge i_clock) disable iff (!i_rstn)
        (acc_take && i_acc_banked && !is_ind && tgt_mem)
        |=> (o_mem_addr == {$past(i_bank_select), $past(i_acc_file)}))
        else $error("banked access did not use the bank select register");

endmodule : iag_indirect_addr
`default_nettype wire

// ---- dv/iag_mem_model.sv ----
// Behavioural data memory answering the address generator
`timescale 1ns/1ps
`default_nettype none

module iag_mem_model (
    // Clock
    input wire logic i_clock,
    // Access from the generator
    input wire logic [iag_pkg::ADDR_W-1:0] i_mem_addr,
    input wire logic i_mem_rd,
    input wire logic i_mem_wr,
    input wire logic [iag_pkg::DATA_W-1:0] i_mem_wdata,
    // Read data, valid only with the read strobe
    output logic [iag_pkg::DATA_W-1:0] o_mem_rdata
);
    import iag_pkg::*;
    logic [DATA_W-1:0] mem_q [0:(1<<ADDR_W)-1];
    logic [DATA_W-1:0] last_q = 8'h00;
    initial begin
        for (int i = 0; i < (1 << ADDR_W); i++) begin
            mem_q[i] = 8'(i) ^ 8'h5A;
        end
    end
    always @(posedge i_clock) begin
        if (i_mem_wr) begin
            mem_q[i_mem_addr] <= i_mem_wdata;
        end
        last_q <= o_mem_rdata;
    end
    // Outside a read the line toggles, never stale data
    assign o_mem_rdata = i_mem_rd ? mem_q[i_mem_addr] : ~last_q;
endmodule : iag_mem_model

`default_nettype wire

// ---- dv/tb_iag_indirect_addr.sv ----
// Self-checking bench for the indirect address generator
`timescale 1ns/1ps
`default_nettype none

module tb_iag_indirect_addr;
    import iag_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic valid, wr, bnk, ext, av, asub, mrd_s, mwr_s, rv, c_rv;
    logic [7:0] file, wd, accum, mrd, rdata, mwd, c_wd, c_rd;
    logic [3:0] bank_select_register;
    logic [1:0] asel, c_strb;
    logic [5:0] alit;
    logic [11:0] maddr, c_addr;
    int error_cnt = 0;
    int n_compared = 0;
    int cycles = 0;

    always #25 clk = ~clk;

    iag_indirect_addr iag_indirect_addr_i (
        .i_clock(clk), .i_rstn(rstn), .i_acc_valid(valid), .i_acc_write(wr),
        .i_acc_banked(bnk), .i_acc_file(file), .i_acc_wdata(wd),
        .i_bank_select(bank_select_register), .i_accum(accum), .i_ext_enable(ext),
        .i_arith_valid(av), .i_arith_sub(asub), .i_arith_sel(asel),
        .i_arith_lit(alit), .o_mem_addr(maddr), .o_mem_rd(mrd_s),
        .o_mem_wr(mwr_s), .o_mem_wdata(mwd), .i_mem_rdata(mrd),
        .o_rdata(rdata), .o_rdata_valid(rv)
    );

    iag_mem_model iag_mem_model_i (
        .i_clock(clk), .i_mem_addr(maddr), .i_mem_rd(mrd_s),
        .i_mem_wr(mwr_s), .i_mem_wdata(mwd), .o_mem_rdata(mrd)
    );

    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    task automatic complete_run();
        $display("mismatches=%0d compared=%0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic access(input logic w, input logic b, input logic [7:0] f,
                          input logic [7:0] d);
        @(posedge clk);
        valid <= 1'b1;
        wr <= w;
        bnk <= b;
        file <= f;
        wd <= d;
        @(posedge clk);
        valid <= 1'b0;
        #1;
        c_addr = maddr;
        c_strb = {mrd_s, mwr_s};
        c_wd = mwd;
        @(posedge clk);
        #1;
        c_rd = rdata;
        c_rv = rv;
    endtask : access

    task automatic rd_mem(input logic b, input logic [7:0] f, input logic [11:0] a);
        access(1'b0, b, f, 8'h00);
        chk(c_strb, 2'b10);
        chk(c_addr, a);
        chk(c_rd, a[7:0] ^ 8'h5A);
        chk(c_rv, 1'b1);
    endtask : rd_mem

    task automatic rd_reg(input logic [7:0] f, input logic [7:0] exp);
        access(1'b0, 1'b0, f, 8'h00);
        chk(c_strb, 2'b00);
        chk(c_rd, exp);
        chk(c_rv, 1'b1);
    endtask : rd_reg

    task automatic arith(input logic s, input logic [1:0] sel, input logic [5:0] lit);
        @(posedge clk);
        av <= 1'b1;
        asub <= s;
        asel <= sel;
        alit <= lit;
        @(posedge clk);
        av <= 1'b0;
    endtask : arith

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_pointer_bytes();
        access(1'b1, 1'b0, 8'hE9, 8'hFF);
        access(1'b1, 1'b0, 8'hEA, 8'h01);
        rd_reg(8'hE9, 8'hFF);
        rd_reg(8'hEA, 8'h01);
        rd_mem(1'b0, 8'hEF, 12'h1FF);
    endtask : t_pointer_bytes

    task automatic t_steps();
        rd_mem(1'b0, 8'hEE, 12'h1FF);
        rd_reg(8'hE9, 8'h00);
        rd_reg(8'hEA, 8'h02);
        rd_mem(1'b0, 8'hED, 12'h200);
        rd_mem(1'b0, 8'hEF, 12'h1FF);
        rd_mem(1'b0, 8'hEC, 12'h200);
        rd_mem(1'b0, 8'hEF, 12'h200);
    endtask : t_steps

    task automatic t_accum_offset();
        @(posedge clk);
        accum <= 8'h81;
        rd_mem(1'b0, 8'hEB, 12'h181);
        @(posedge clk);
        accum <= 8'h7F;
        rd_mem(1'b0, 8'hEB, 12'h27F);
        rd_mem(1'b0, 8'hEF, 12'h200);
    endtask : t_accum_offset

    task automatic t_cross_targets();
        access(1'b1, 1'b0, 8'hE9, 8'hE7);
        access(1'b1, 1'b0, 8'hEA, 8'h0F);
        rd_reg(8'hEF, 8'h00);
        access(1'b1, 1'b0, 8'hEF, 8'h77);
        chk(c_strb, 2'b00);
        access(1'b1, 1'b0, 8'hE9, 8'hD9);
        access(1'b1, 1'b0, 8'hEF, 8'h34);
        chk(c_strb, 2'b00);
        rd_reg(8'hD9, 8'h34);
        access(1'b1, 1'b0, 8'hE9, 8'hEA);
        access(1'b1, 1'b0, 8'hEE, 8'h05);
        chk(c_strb, 2'b00);
        rd_reg(8'hE9, 8'hEA);
        rd_reg(8'hEA, 8'h05);
        access(1'b1, 1'b0, 8'hEA, 8'h0F);
        access(1'b1, 1'b0, 8'hE9, 8'hE8);
        access(1'b1, 1'b0, 8'hEF, 8'h66);
        chk(c_strb, 2'b01);
        chk(c_addr, 12'hFE8);
    endtask : t_cross_targets

    task automatic t_indexed();
        @(posedge clk);
        ext <= 1'b1;
        bank_select_register <= 4'h2;
        access(1'b1, 1'b0, 8'hD9, 8'h00);
        access(1'b1, 1'b0, 8'hDA, 8'h03);
        rd_mem(1'b0, 8'h10, 12'h310);
        rd_mem(1'b0, 8'h5F, 12'h35F);
        rd_mem(1'b0, 8'h60, 12'hF60);
        rd_mem(1'b1, 8'h10, 12'h210);
        rd_mem(1'b0, 8'hDF, 12'h300);
        arith(1'b0, 2'h2, 6'h05);
        rd_mem(1'b0, 8'hDF, 12'h305);
        arith(1'b1, 2'h2, 6'h06);
        rd_mem(1'b0, 8'hDF, 12'h2FF);
        @(posedge clk);
        ext <= 1'b0;
        arith(1'b0, 2'h2, 6'h01);
        rd_mem(1'b0, 8'hDF, 12'h2FF);
        rd_mem(1'b0, 8'h10, 12'h010);
    endtask : t_indexed

    task automatic t_mem_write();
        access(1'b1, 1'b0, 8'h10, 8'hA5);
        chk(c_strb, 2'b01);
        chk(c_wd, 8'hA5);
        access(1'b0, 1'b0, 8'h10, 8'h00);
        chk(c_rd, 8'hA5);
    endtask : t_mem_write

    // ------------------------------------------------------------
    // Main sequence and hang guard
    // ------------------------------------------------------------
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            error_cnt++;
            complete_run();
        end
    end

    initial begin
        {valid, wr, bnk, ext, av, asub} = 6'h00;
        file = 8'h00;
        wd = 8'h00;
        accum = 8'h00;
        bank_select_register = 4'h0;
        asel = 2'h0;
        alit = 6'h00;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        t_pointer_bytes();
        t_steps();
        t_accum_offset();
        t_cross_targets();
        t_indexed();
        t_mem_write();
        complete_run();
    end
endmodule : tb_iag_indirect_addr

`default_nettype wire
